// file: rtl/ffps_top.sv
// feedforward input selection, scaling, filtering and p/pi select
// Behaviour
// - torque ff select: 0 off (default), 2 analog torque; applies after restart
// - torque gain 10..100 in 0.1 V per rated torque, default 30, immediate
// - torque ff equals input volts divided by torque gain
// - torque ff and analog torque limit are mutually exclusive
// - torque input low-pass filter, 0.01 ms units, 0 means none, immediate
// - speed ff applied only in position control
// - speed ff select: 0 off (default), 1 analog speed; after restart
// - speed gain 150..3000 in 0.01 V per rated speed, default 600, immediate
// - speed ff equals input volts divided by speed gain
// - select input high gives pi, low gives p-only speed loop
// - proportional select ignored in torque control
// - control method codes 0..b as listed
`timescale 1ns/1ns
module ffps_top
  import ffps_pkg::*;
#(
  parameter int FILT_CYC = FILT_TICK_CYC
)
(
  input wire logic ref_clk, // 25 mhz clock
  input wire logic srst, // sync reset, active high
  input wire logic [3:0] reg_addr, // register word address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic ctrl_update, // control update strobe
  input wire logic signed [15:0] speed_ain, // analog speed input, 1 lsb = 1 mv
  input wire logic signed [15:0] torque_ain, // analog torque input, 1 lsb = 1 mv
  input wire logic prop_control_select_n, // low selects p control
  input wire logic mode_alt, // alternate method of a combined pair
  input wire logic signed [15:0] speed_loop_tq, // speed loop torque out
  input wire logic signed [15:0] pos_loop_spd, // position loop speed out
  output logic signed [15:0] torque_ref_out, // torque ref incl ff, 1/4096 rated
  output logic signed [15:0] speed_ref_out, // speed ref incl ff, 1/4096 rated
  output logic speed_loop_p_only, // speed loop in p control
  output logic [3:0] active_mode, // one-hot active mode
  output logic cfg_conflict // torque ff with analog torque limit
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] tq_sel_pend;
    logic [3:0] sp_sel_pend;
    logic [3:0] cm_pend;
    logic tlim_pend;
    logic [3:0] tq_sel;
    logic [3:0] sp_sel;
    logic [3:0] cm;
    logic tlim;
    logic [15:0] tq_gain;
    logic [15:0] sp_gain;
    logic [15:0] tq_tc;
    logic [15:0] tick_cnt;
    logic tick;
    logic [15:0] rdata;
    logic signed [15:0] tq_out;
    logic signed [15:0] sp_out;
    logic p_only;
    ffps_mode_type mode;
    logic conflict;
  } ffps_st_type;
  ffps_st_type st_r, st_nxt;
  ffps_filt_if fif ();
  ffps_lpf u_lpf (
    .ref_clk(ref_clk),
    .srst(srst),
    .fi(fif)
  );
  assign fif.tick = st_r.tick;
  assign fif.tc = st_r.tq_tc;
  assign fif.din = torque_ain;
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v < lo)
      return lo;
    else if (v > hi)
      return hi;
    else
      return v;
  endfunction
  // volts (mv) / gain -> 1/4096 rated units; unit_mv is mv per gain step
  function automatic logic signed [15:0] scale_ff(input logic signed [15:0] mv,
                                                 input logic [15:0] gain,
                                                 input logic [15:0] unit_mv);
    logic signed [39:0] num;
    logic signed [39:0] den;
    logic signed [39:0] q;
    num = 40'(mv) <<< 12;
    den = $signed({8'h00, 16'h0000, gain}) * $signed({24'h000000, unit_mv});
    q = num / den;
    if (q > 40'sd32767)
      return 16'sh7fff;
    else if (q < -40'sd32768)
      return 16'sh8000;
    else
      return q[15:0];
  endfunction
  function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    if (s > 17'sd32767)
      return 16'sh7fff;
    else if (s < -17'sd32768)
      return 16'sh8000;
    else
      return s[15:0];
  endfunction
  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic signed [15:0] tq_ff;
  logic signed [15:0] sp_ff;
  logic tq_ff_on;
  logic sp_ff_on;
  ffps_mode_type mode_c;
  always_comb
  begin
    st_nxt = st_r;
    // filter time base
    if (st_r.tick_cnt == 16'(FILT_CYC - 1))
    begin
      st_nxt.tick_cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
      st_nxt.tick = 1'b0;
    end
    // register writes
    if (reg_wr)
    begin
      if (reg_addr == OFS_FF_SELECT)
      begin
        st_nxt.tq_sel_pend = reg_wdata[TQ_SEL_LSB +: 4];
        st_nxt.sp_sel_pend = reg_wdata[SP_SEL_LSB +: 4];
        st_nxt.tlim_pend = reg_wdata[TLIM_BIT];
      end
      else if (reg_addr == OFS_CTRL_METHOD)
        st_nxt.cm_pend = reg_wdata[3:0];
      else if (reg_addr == OFS_TQ_GAIN)
        st_nxt.tq_gain = clamp16(reg_wdata, TQ_GAIN_MIN, TQ_GAIN_MAX);
      else if (reg_addr == OFS_TQ_FILT)
        st_nxt.tq_tc = reg_wdata;
      else if (reg_addr == OFS_SP_GAIN)
        st_nxt.sp_gain = clamp16(reg_wdata, SP_GAIN_MIN, SP_GAIN_MAX);
      else if (reg_addr == OFS_RESTART && reg_wdata[0])
      begin
        // restart-class settings only land here
        st_nxt.tq_sel = st_r.tq_sel_pend;
        st_nxt.sp_sel = st_r.sp_sel_pend;
        st_nxt.cm = (st_r.cm_pend > CM_POS_INHIBIT) ? CM_SPEED : st_r.cm_pend;
        st_nxt.tlim = st_r.tlim_pend;
        // flag lands with the selects so it never lags the gating below
        st_nxt.conflict = (st_r.tq_sel_pend == TQ_SEL_AIN) && st_r.tlim_pend;
      end
    end
    // active mode from method and pair select
    case (st_r.cm)
      CM_POS, CM_POS_INHIBIT: mode_c = FFPS_M_POS;
      CM_TORQUE: mode_c = FFPS_M_TORQUE;
      CM_INT_SPEED: mode_c = FFPS_M_INT;
      CM_IS_SPD: mode_c = mode_alt ? FFPS_M_SPEED : FFPS_M_INT;
      CM_IS_POS: mode_c = mode_alt ? FFPS_M_POS : FFPS_M_INT;
      CM_IS_TRQ: mode_c = mode_alt ? FFPS_M_TORQUE : FFPS_M_INT;
      CM_POS_SPD: mode_c = mode_alt ? FFPS_M_SPEED : FFPS_M_POS;
      CM_POS_TRQ: mode_c = mode_alt ? FFPS_M_TORQUE : FFPS_M_POS;
      CM_TRQ_SPD: mode_c = mode_alt ? FFPS_M_SPEED : FFPS_M_TORQUE;
      default: mode_c = FFPS_M_SPEED;
    endcase
    st_nxt.mode = mode_c;
    // torque ff dropped when analog torque limit is configured
    tq_ff_on = (st_r.tq_sel == TQ_SEL_AIN) && !st_r.tlim;
    // gated on the mode that is shown on active_mode, not the one pending
    sp_ff_on = (st_r.sp_sel == SP_SEL_AIN) && (st_r.mode == FFPS_M_POS);
    tq_ff = tq_ff_on ? scale_ff(fif.dout, st_r.tq_gain, 16'h0064) : 16'sh0000;
    sp_ff = sp_ff_on ? scale_ff(speed_ain, st_r.sp_gain, 16'h000a) : 16'sh0000;
    if (ctrl_update)
    begin
      st_nxt.tq_out = sat_add(speed_loop_tq, tq_ff);
      st_nxt.sp_out = sat_add(pos_loop_spd, sp_ff);
    end
    // p only while select low, never in torque control; internal speed is a speed loop
    st_nxt.p_only = !prop_control_select_n && (mode_c != FFPS_M_TORQUE);
    // read data
    st_nxt.rdata = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == OFS_FF_SELECT)
        st_nxt.rdata = {7'h00, st_r.tlim_pend, st_r.sp_sel_pend, st_r.tq_sel_pend};
      else if (reg_addr == OFS_CTRL_METHOD)
        st_nxt.rdata = {12'h000, st_r.cm_pend};
      else if (reg_addr == OFS_TQ_GAIN)
        st_nxt.rdata = st_r.tq_gain;
      else if (reg_addr == OFS_TQ_FILT)
        st_nxt.rdata = st_r.tq_tc;
      else if (reg_addr == OFS_SP_GAIN)
        st_nxt.rdata = st_r.sp_gain;
      else if (reg_addr == OFS_STATUS)
        st_nxt.rdata = {10'h000, st_r.conflict, st_r.p_only, st_r.mode};
      else if (reg_addr == OFS_ACT_MODE)
        st_nxt.rdata = {3'h0, st_r.tlim, st_r.sp_sel, st_r.tq_sel, st_r.cm};
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.tq_gain <= TQ_GAIN_RST;
      st_r.sp_gain <= SP_GAIN_RST;
      st_r.tq_tc <= TQ_FILT_RST;
      st_r.tq_sel_pend <= TQ_SEL_OFF;
      st_r.tq_sel <= TQ_SEL_OFF;
      st_r.sp_sel_pend <= SP_SEL_OFF;
      st_r.sp_sel <= SP_SEL_OFF;
      st_r.cm_pend <= CM_SPEED;
      st_r.cm <= CM_SPEED;
      st_r.mode <= FFPS_M_SPEED;
    end
    else
      st_r <= st_nxt;
  end
  assign reg_rdata = st_r.rdata;
  assign torque_ref_out = st_r.tq_out;
  assign speed_ref_out = st_r.sp_out;
  assign speed_loop_p_only = st_r.p_only;
  assign active_mode = st_r.mode;
  assign cfg_conflict = st_r.conflict;
endmodule // ffps_top

// file: rtl/ffps_pkg.sv
// package: constants and types for the feedforward and p/pi select block
package ffps_pkg;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int ADC_W = 16;
  localparam int LOOP_W = 16;
  // ----------------------------------------------------------------------
  // register offsets (word addresses on the plain port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_FF_SELECT = 4'h0;
  localparam logic [3:0] OFS_CTRL_METHOD = 4'h1;
  localparam logic [3:0] OFS_TQ_GAIN = 4'h2;
  localparam logic [3:0] OFS_TQ_FILT = 4'h3;
  localparam logic [3:0] OFS_SP_GAIN = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  localparam logic [3:0] OFS_RESTART = 4'h6;
  localparam logic [3:0] OFS_ACT_MODE = 4'h7;
  // ----------------------------------------------------------------------
  // field positions in the select register
  // ----------------------------------------------------------------------
  localparam int TQ_SEL_LSB = 0;
  localparam int SP_SEL_LSB = 4;
  localparam int TLIM_BIT = 8;
  // ----------------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] TQ_SEL_OFF = 4'h0;
  localparam logic [3:0] TQ_SEL_AIN = 4'h2;
  localparam logic [3:0] SP_SEL_OFF = 4'h0;
  localparam logic [3:0] SP_SEL_AIN = 4'h1;
  localparam logic [3:0] CM_SPEED = 4'h0;
  localparam logic [3:0] CM_POS = 4'h1;
  localparam logic [3:0] CM_TORQUE = 4'h2;
  localparam logic [3:0] CM_INT_SPEED = 4'h3;
  localparam logic [3:0] CM_IS_SPD = 4'h4;
  localparam logic [3:0] CM_IS_POS = 4'h5;
  localparam logic [3:0] CM_IS_TRQ = 4'h6;
  localparam logic [3:0] CM_POS_SPD = 4'h7;
  localparam logic [3:0] CM_POS_TRQ = 4'h8;
  localparam logic [3:0] CM_TRQ_SPD = 4'h9;
  localparam logic [3:0] CM_SPD_ZCLAMP = 4'ha;
  localparam logic [3:0] CM_POS_INHIBIT = 4'hb;
  localparam logic [15:0] TQ_GAIN_MIN = 16'h000a;
  localparam logic [15:0] TQ_GAIN_MAX = 16'h0064;
  localparam logic [15:0] TQ_GAIN_RST = 16'h001e;
  localparam logic [15:0] SP_GAIN_MIN = 16'h0096;
  localparam logic [15:0] SP_GAIN_MAX = 16'h0bb8;
  localparam logic [15:0] SP_GAIN_RST = 16'h0258;
  localparam logic [15:0] TQ_FILT_RST = 16'h0000;
  // ----------------------------------------------------------------------
  // timing: filter step is 0.01 ms
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int FILT_TICK_NS = 10000;
  localparam int FILT_TICK_CYC = FILT_TICK_NS / (1000000000 / CLK_HZ);
  // ----------------------------------------------------------------------
  // active loop mode
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FFPS_M_SPEED = 4'b0001,
    FFPS_M_POS = 4'b0010,
    FFPS_M_TORQUE = 4'b0100,
    FFPS_M_INT = 4'b1000
  } ffps_mode_type;
endpackage

// file: rtl/ffps_filt_if.sv
// interface: link between the top and the torque input filter
`timescale 1ns/1ns
interface ffps_filt_if;
  logic tick;
  logic [15:0] tc;
  logic signed [15:0] din;
  logic signed [15:0] dout;
  modport top (output tick, output tc, output din, input dout);
  modport filt (input tick, input tc, input din, output dout);
endinterface // ffps_filt_if

// file: rtl/ffps_lpf.sv
// first order low-pass filter for the analog torque input
`timescale 1ns/1ns
module ffps_lpf
  import ffps_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic srst, // sync reset
  ffps_filt_if.filt fi // filter link
);
  typedef struct packed {
    logic signed [47:0] acc;
  } ffps_lpf_st_type;
  ffps_lpf_st_type st_r, st_nxt;
  logic signed [47:0] err;
  always_comb
  begin
    st_nxt = st_r;
    err = ($signed({{32{fi.din[15]}}, fi.din}) <<< 32) - st_r.acc;
    if (fi.tc == 16'h0000)
    begin
      st_nxt.acc = $signed({{32{fi.din[15]}}, fi.din}) <<< 32;
    end
    else if (fi.tick)
    begin
      // one step per 0.01 ms: acc += err / (tc + 1)
      // divisor kept 17 bits wide so the largest setting cannot wrap to zero
      st_nxt.acc = st_r.acc + (err / $signed({31'h0, 17'(fi.tc) + 17'h00001}));
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign fi.dout = st_r.acc[47:32];
endmodule // ffps_lpf

// file: verification/ffps_monitor.sv
// checker: port-level properties of the feedforward and p/pi select block
`timescale 1ns/1ns
module ffps_monitor
  import ffps_pkg::*;
#(
  parameter int FILT_CYC = 2
)
(
  input wire logic ref_clk, // clock
  input wire logic srst, // sync reset
  input wire logic [3:0] reg_addr, // address
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic ctrl_update, // update strobe
  input wire logic prop_control_select_n, // p request
  input wire logic signed [15:0] speed_loop_tq, // loop torque
  input wire logic signed [15:0] pos_loop_spd, // loop speed
  input wire logic signed [15:0] torque_ref_out, // torque out
  input wire logic signed [15:0] speed_ref_out, // speed out
  input wire logic speed_loop_p_only, // p only
  input wire logic [3:0] active_mode, // one-hot mode
  input wire logic cfg_conflict // conflict flag
);
  default clocking mon_clk @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not idle");
  unmapped_rd_a: assert property (reg_rd && reg_addr > 4'h7 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  mode_onehot_a: assert property ($onehot(active_mode))
    else $error("active mode not one-hot");
  pi_high_a: assert property (prop_control_select_n |=> !speed_loop_p_only)
    else $error("p control without request");
  p_low_a: assert property (!prop_control_select_n |=>
    speed_loop_p_only || active_mode == 4'h4) else $error("p request not honoured");
  torque_no_p_a: assert property (active_mode == 4'h4 |-> !speed_loop_p_only)
    else $error("p control in torque mode");
  ref_hold_a: assert property (!ctrl_update |=>
    $stable(torque_ref_out) && $stable(speed_ref_out)) else $error("ref moved without update");
  spd_ff_gate_a: assert property (ctrl_update && active_mode != 4'h2 &&
    $stable(active_mode) |=> speed_ref_out == $past(pos_loop_spd))
    else $error("speed ff outside position");
  conflict_gate_a: assert property (ctrl_update && cfg_conflict |=>
    torque_ref_out == $past(speed_loop_tq)) else $error("torque ff during conflict");
  pos_upd_c: cover property (ctrl_update && active_mode == 4'h2);
  p_only_c: cover property (speed_loop_p_only);
  conflict_c: cover property (ctrl_update && cfg_conflict);
endmodule // ffps_monitor

bind ffps_top ffps_monitor #(.FILT_CYC(FILT_CYC)) mon_u (.ref_clk, .srst, .reg_addr, .reg_rd,
  .reg_rdata, .ctrl_update, .prop_control_select_n, .speed_loop_tq, .pos_loop_spd,
  .torque_ref_out, .speed_ref_out, .speed_loop_p_only, .active_mode, .cfg_conflict);

// file: verification/ffps_host_model.sv
// host controller model: analog references and p select line
`timescale 1ns/1ns
module ffps_host_model
(
  input wire logic ref_clk, // clock
  input wire logic signed [15:0] spd_cmd, // wanted speed level, mv
  input wire logic signed [15:0] tq_cmd, // wanted torque level, mv
  input wire logic p_req, // ask for p control
  input wire logic alt_req, // second method of a pair
  output logic signed [15:0] speed_ain = 16'h0000, // speed input, mv
  output logic signed [15:0] torque_ain = 16'h0000, // torque input, mv
  output logic prop_control_select_n = 1'b1, // p select, low active
  output logic mode_alt = 1'b0 // pair select
);
  // levels move only after an edge, like a converter refresh
  always @(posedge ref_clk)
  begin
    speed_ain <= spd_cmd;
    torque_ain <= tq_cmd;
    prop_control_select_n <= !p_req;
    mode_alt <= alt_req;
  end
endmodule // ffps_host_model

// file: verification/ffps_test.sv
// testbench: register access, feedforward and p/pi select scenarios
`timescale 1ns/1ns
module ffps_test;
  import ffps_pkg::*;
  localparam logic [3:0] M1 [13] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8, 4'h2, 4'h2,
    4'h4, 4'h1, 4'h2, 4'h1};
  localparam logic [3:0] M2 [13] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4, 4'h1, 4'h4,
    4'h1, 4'h1, 4'h2, 4'h1};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ctrl_update = 1'b0;
  logic signed [15:0] spd_cmd = 16'h0000;
  logic signed [15:0] tq_cmd = 16'h0000;
  logic p_req = 1'b0;
  logic alt_req = 1'b0;
  logic signed [15:0] speed_loop_tq = 16'h0064;
  logic signed [15:0] pos_loop_spd = 16'h0032;
  logic [15:0] reg_rdata;
  logic signed [15:0] speed_ain, torque_ain, torque_ref_out, speed_ref_out;
  logic prop_control_select_n, mode_alt, speed_loop_p_only, cfg_conflict;
  logic [3:0] active_mode;
  logic [3:0] em;
  logic ep;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int m;
  int a;
  ffps_host_model host_u (.ref_clk, .spd_cmd, .tq_cmd, .p_req, .alt_req, .speed_ain,
    .torque_ain, .prop_control_select_n, .mode_alt);
  ffps_top #(.FILT_CYC(2)) dut_u (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ctrl_update, .speed_ain, .torque_ain, .prop_control_select_n, .mode_alt,
    .speed_loop_tq, .pos_loop_spd, .torque_ref_out, .speed_ref_out, .speed_loop_p_only,
    .active_mode, .cfg_conflict);
  always #20 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one access plus an idle cycle, so a strobe is never set twice in a step
  task automatic bus(input logic w, input logic [3:0] ad, input logic [15:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w)
      chk(reg_rdata, d);
    @(posedge ref_clk);
  endtask
  task automatic upd(input logic [15:0] et, input logic [15:0] es);
    ctrl_update <= 1'b1;
    @(posedge ref_clk);
    ctrl_update <= 1'b0;
    #1;
    chk(torque_ref_out, et);
    chk(speed_ref_out, es);
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    bus(0, OFS_TQ_GAIN, TQ_GAIN_RST);
    bus(0, OFS_SP_GAIN, SP_GAIN_RST);
    bus(0, OFS_TQ_FILT, TQ_FILT_RST);
    bus(0, OFS_ACT_MODE, 16'h0000);
    bus(0, 4'h9, 16'h0000);
    bus(1, OFS_TQ_GAIN, 16'h0005);
    bus(0, OFS_TQ_GAIN, TQ_GAIN_MIN);
    bus(1, OFS_TQ_GAIN, 16'h0065);
    bus(0, OFS_TQ_GAIN, TQ_GAIN_MAX);
    bus(1, OFS_SP_GAIN, 16'h0095);
    bus(0, OFS_SP_GAIN, SP_GAIN_MIN);
    bus(1, OFS_SP_GAIN, 16'h0bb9);
    bus(0, OFS_SP_GAIN, SP_GAIN_MAX);
    tq_cmd <= 16'h0bb8;
    spd_cmd <= 16'h1770;
    bus(1, OFS_FF_SELECT, 16'h0012);
    bus(1, OFS_CTRL_METHOD, 16'h0001);
    upd(16'h0064, 16'h0032);
    bus(1, OFS_RESTART, 16'h0001);
    upd(16'h0530, 16'h0365);
    bus(1, OFS_TQ_GAIN, 16'h001e);
    bus(1, OFS_SP_GAIN, 16'h0258);
    upd(16'h1064, 16'h1032);
    tq_cmd <= 16'hf448;
    repeat (3) @(posedge ref_clk);
    upd(16'hf064, 16'h1032);
    bus(0, OFS_STATUS, 16'h0002);
    bus(0, OFS_ACT_MODE, 16'h0121);
    bus(1, OFS_CTRL_METHOD, 16'h0000);
    bus(1, OFS_RESTART, 16'h0001);
    upd(16'hf064, 16'h0032);
    bus(1, OFS_FF_SELECT, 16'h0102);
    bus(1, OFS_RESTART, 16'h0001);
    bus(0, OFS_STATUS, 16'h0021);
    chk({15'h0000, cfg_conflict}, 16'h0001);
    upd(16'h0064, 16'h0032);
    // filter passes through while tc is 0, so it starts smoothing from exactly zero
    tq_cmd <= 16'h0000;
    bus(1, OFS_FF_SELECT, 16'h0002);
    bus(1, OFS_RESTART, 16'h0001);
    bus(1, OFS_TQ_FILT, 16'h0004);
    tq_cmd <= 16'h0bb8;
    upd(16'h0064, 16'h0032);
    chk({15'h0000, torque_ref_out < 16'sh0800}, 16'h0001);
    repeat (200) @(posedge ref_clk);
    // filter sits just under 3000 mv: 2999 * 4096 / 3000 = 4094, plus loop 100
    upd(16'h1062, 16'h0032);
    chk({15'h0000, torque_ref_out > 16'sh1040}, 16'h0001);
    bus(1, OFS_FF_SELECT, 16'h0000);
    for (m = 0; m < 13; m++)
      for (a = 0; a < 2; a++)
      begin
        em = a[0] ? M2[m] : M1[m];
        ep = (a[0] ^ m[0]) && em != 4'h4;
        p_req <= a[0] ^ m[0];
        alt_req <= a[0];
        bus(1, OFS_CTRL_METHOD, 16'(m));
        bus(1, OFS_RESTART, 16'h0001);
        bus(0, OFS_STATUS, {10'h000, 1'b0, ep, em});
        chk({10'h000, cfg_conflict, speed_loop_p_only, active_mode}, {10'h000, 1'b0, ep, em});
      end
    print_verdict();
  end
endmodule // ffps_test
